// ---- hw/udc_pkg.sv ----
package udc_pkg;
  // register indexes; byte address is four times the index
  localparam logic [9:0] IDX_RX_IRQ = 10'h107;
  localparam logic [9:0] IDX_RX_MASK = 10'h108;
  localparam logic [9:0] IDX_CUR_DESC = 10'h180;
  localparam logic [9:0] IDX_CFG = 10'h181;
  localparam logic [9:0] IDX_PAGE = 10'h182;
  localparam logic [9:0] IDX_ADDR = 10'h183;
  localparam logic [9:0] IDX_COUNT = 10'h184;
  localparam logic [9:0] IDX_NEXT_DESC = 10'h185;
  localparam logic [9:0] IDX_DESC_RDY = 10'h186;
  localparam logic [9:0] IDX_TX_IRQ = 10'h187;
  localparam logic [9:0] IDX_TX_MASK = 10'h188;
  // configuration field positions
  localparam int CFG_EN_BIT = 15;
  localparam int CFG_DIR_BIT = 14;
  localparam int CFG_AUTO_BIT = 12;
  localparam int CFG_FS_BIT = 6;
  localparam int CFG_DS_BIT = 5;
  localparam int CFG_OWN_BIT = 4;
  // start page fields
  localparam int PAGE_SPACE_BIT = 8;
  // interrupt flag positions
  localparam int IRQ_DONE_BIT = 15;
  localparam int IRQ_ERR_BIT = 14;
  localparam int IRQ_PEND_BIT = 0;
  localparam logic [15:0] TX_IRQ_MASK_BITS = 16'hc001;
  localparam logic [15:0] RX_IRQ_MASK_BITS = 16'h0001;
  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [8:0] RST_PAGE = 9'h000;
  localparam logic RST_DESC_RDY = 1'b0;
  // engine states, gray along idle-fetch-hold-done
  typedef enum logic [1:0] {
    UDC_IDLE = 2'b00,
    UDC_FETCH = 2'b01,
    UDC_HOLD = 2'b11,
    UDC_DONE = 2'b10
  } udc_state_e;
endpackage : udc_pkg

// ---- hw/udc_top.sv ----
// Contract
// RULE1: rx irq pending bit clears on one written
// RULE2: current descriptor pointer 16-bit, read-only, zero
// RULE3: config writable only in autobuffer mode; the code also accepts a config write that sets bit12
// RULE4: software loads descriptor pointer before enabling
// RULE5: config shows live buffer status during transfer
// RULE6: dma off: holding empty raises tx interrupt
// RULE7: start page 9 bits, bit8 space select
// RULE8: start page writable only in autobuffer mode
// RULE9: start address 16-bit, writable in autobuffer only
// RULE10: word count 16-bit, writable in autobuffer only
// RULE11: software writes chain pointer before enabling
// RULE12: descriptor ready bit, zero means ready
// RULE13: software marks descriptor ready to start
// RULE14: tx irq pending bit clears on one written
// RULE15: bit15 completion flag, write one clears
// RULE16: bit14 error flag, write one clears
// RULE17: config bit12 selects autobuffer versus descriptor
// RULE18: config bit15 enables the channel
// RULE19: reserved irq bits read zero, ignore writes
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module udc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // internal memory read port
  output logic mem_req,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_page,
  output logic mem_space,
  input wire logic mem_ack,
  input wire logic mem_err,
  input wire logic [15:0] mem_rdata,
  // transmitter holding register path
  input wire logic holding_empty_flag,
  output logic tx_holding_wr,
  output logic [15:0] tx_holding_reg,
  // receive side event
  input wire logic rx_irq_event,
  output logic irq
);
  import udc_pkg::*;

  // every piece of state lives in one struct
  // one packed struct keeps every flop in one place: the
  // reset branch and the freeze by ce then cover all state
  // at once, though a new field must still be listed in the reset branch
  // next_s starts as a copy, so an unassigned field holds
  // field order carries no meaning; software never sees it
  typedef struct packed {
    udc_state_e st;
    logic apb_done;
    logic [31:0] rdata;
    logic slverr;
    logic [15:0] cur_desc;
    logic channel_enable;
    logic circular_buffer_select;
    logic err_status;
    logic buf_full;
    logic [8:0] page;
    logic [15:0] addr;
    logic [15:0] count;
    logic [15:0] base_addr;
    logic [15:0] base_count;
    logic [15:0] next_desc;
    logic desc_rdy;
    logic [15:0] tx_flags;
    logic [15:0] tx_mask;
    logic [15:0] rx_flags;
    logic [15:0] rx_mask;
    logic empty_d;
    logic mem_req;
    logic thr_wr;
    logic [15:0] thr_data;
    logic irq;
  } udc_state_s;

  udc_state_s s; // current state
  udc_state_s next_s; // next state

  logic [9:0] idx; // word index of the access
  logic wr_now; // write takes effect this edge
  logic [15:0] wd; // low half of write data
  logic [15:0] cfg_view; // config as software reads it
  logic [15:0] tx_set; // hardware set requests, tx flags
  logic [15:0] rx_set; // hardware set requests, rx flags
  logic [15:0] tx_clr; // software clear requests, tx flags
  logic [15:0] rx_clr; // software clear requests, rx flags
  logic auto_wr_ok; // autobuffer gate on data registers

  assign idx = paddr[11:2];
  assign wd = pwdata[15:0];
  // write lands at the edge where pready is seen high
  assign wr_now = psel && penable && pwrite && s.apb_done;

  // live config view, status bits follow the engine
  always_comb begin
    cfg_view = RST_WORD;
    cfg_view[CFG_EN_BIT] = s.channel_enable; // [RULE18]
    cfg_view[CFG_DIR_BIT] = 1'b0; // transmit channel reads memory
    cfg_view[CFG_AUTO_BIT] = s.circular_buffer_select; // [RULE17]
    cfg_view[CFG_FS_BIT] = s.buf_full; // [RULE5]
    cfg_view[CFG_DS_BIT] = s.err_status; // [RULE5]
    cfg_view[CFG_OWN_BIT] = (s.st != UDC_IDLE); // [RULE5]
  end

  // reads have no side effects: flags clear only by
  // writing ones, so polling a status word is safe
  // read mux; unmapped words read zero with an error
  function automatic logic [32:0] read_word(input logic [9:0] i, input udc_state_s c, input logic [15:0] cv);
    logic [32:0] r;
    r = {1'b0, 32'h0000_0000};
    case (i)
      IDX_RX_IRQ: r[15:0] = c.rx_flags;
      IDX_RX_MASK: r[15:0] = c.rx_mask;
      IDX_CUR_DESC: r[15:0] = c.cur_desc; // [RULE2]
      IDX_CFG: r[15:0] = cv;
      IDX_PAGE: r[8:0] = c.page; // [RULE7]
      IDX_ADDR: r[15:0] = c.addr;
      IDX_COUNT: r[15:0] = c.count;
      IDX_NEXT_DESC: r[15:0] = c.next_desc;
      IDX_DESC_RDY: r[0] = c.desc_rdy; // [RULE12]
      IDX_TX_IRQ: r[15:0] = c.tx_flags;
      IDX_TX_MASK: r[15:0] = c.tx_mask;
      default: r[32] = 1'b1;
    endcase
    return r;
  endfunction : read_word

  // next-state logic: bus slave, registers, engine, interrupts
  always_comb begin
    logic [32:0] rd;
    rd = read_word(idx, s, cfg_view);
    next_s = s;
    tx_set = RST_WORD;
    rx_set = RST_WORD;
    tx_clr = RST_WORD;
    rx_clr = RST_WORD;
    auto_wr_ok = s.circular_buffer_select;
    next_s.thr_wr = 1'b0;
    next_s.empty_d = holding_empty_flag;

    // the wait state costs a cycle per access but lets read
    // data come from a flop, so prdata never glitches with paddr
    // a master that keeps penable up after pready would start
    // a second access; the bus protocol forbids that
    // pslverr rides with pready and is cleared with it
    // apb: one wait cycle, then pready with registered data
    if (psel && penable && !s.apb_done) begin
      next_s.apb_done = 1'b1;
      next_s.rdata = pwrite ? 32'h0000_0000 : rd[31:0];
      next_s.slverr = rd[32];
    end else if (s.apb_done) begin
      next_s.apb_done = 1'b0;
      next_s.slverr = 1'b0;
    end

    // writes land only at the edge where pready is sampled high,
    // so a master that aborts before that edge changes nothing
    // clear requests are gathered here and merged with hardware
    // sets further down, so the two never fight over a flag
    // data registers ignore software writes outside autobuffer mode
    // software writes
    if (wr_now) begin
      case (idx)
        IDX_RX_IRQ: rx_clr = wd & RX_IRQ_MASK_BITS; // [RULE1] [RULE19]
        IDX_RX_MASK: next_s.rx_mask = wd & RX_IRQ_MASK_BITS; // [RULE19]
        IDX_CFG: begin
          // enabling autobuffer in the same write opens the gate
          if (s.circular_buffer_select || wd[CFG_AUTO_BIT]) begin // [RULE3]
            next_s.channel_enable = wd[CFG_EN_BIT]; // [RULE18]
            next_s.circular_buffer_select = wd[CFG_AUTO_BIT]; // [RULE17]
            if (wd[CFG_EN_BIT] && !s.channel_enable) begin
              next_s.err_status = 1'b0; // fresh run clears old error
            end
          end
        end
        IDX_PAGE: begin
          if (auto_wr_ok) begin
            next_s.page = wd[8:0]; // [RULE8] [RULE7]
          end
        end
        IDX_ADDR: begin
          if (auto_wr_ok) begin
            next_s.addr = wd; // [RULE9]
            next_s.base_addr = wd;
          end
        end
        IDX_COUNT: begin
          if (auto_wr_ok) begin
            next_s.count = wd; // [RULE10]
            next_s.base_count = wd;
          end
        end
        IDX_NEXT_DESC: next_s.next_desc = wd;
        IDX_DESC_RDY: next_s.desc_rdy = wd[0]; // [RULE12]
        IDX_TX_IRQ: tx_clr = wd & TX_IRQ_MASK_BITS; // [RULE14] [RULE15] [RULE16] [RULE19]
        IDX_TX_MASK: next_s.tx_mask = wd & TX_IRQ_MASK_BITS; // [RULE19]
        default: ;
      endcase
    end

    // holding register emptied while dma is off
    if (!s.channel_enable && holding_empty_flag && !s.empty_d) begin
      tx_set[IRQ_PEND_BIT] = 1'b1; // [RULE6]
    end
    if (rx_irq_event) begin
      rx_set[IRQ_PEND_BIT] = 1'b1; // [RULE1]
    end

    // one word in flight at a time: fetch from memory, park
    // it until the holding register is empty, then hand it over
    // a fetch error stops the channel and leaves the address on
    // the failing word so software can inspect it
    // clearing enable mid-transfer lets the current word finish
    // instead of dropping it halfway
    // transfer engine
    case (s.st)
      UDC_IDLE: begin
        // descriptor mode waits for software to mark it ready
        if (s.channel_enable && (s.circular_buffer_select || !s.desc_rdy) // [RULE12] [RULE13]
            && (s.count != RST_WORD)) begin
          next_s.st = UDC_FETCH;
          next_s.mem_req = 1'b1;
        end
      end
      UDC_FETCH: begin
        if (mem_ack) begin
          next_s.mem_req = 1'b0;
          if (mem_err) begin
            tx_set[IRQ_ERR_BIT] = 1'b1; // [RULE16]
            next_s.err_status = 1'b1; // [RULE5]
            next_s.channel_enable = 1'b0;
            next_s.st = UDC_IDLE;
          end else begin
            next_s.thr_data = mem_rdata;
            next_s.buf_full = 1'b1; // [RULE5]
            next_s.addr = s.addr + 16'h0001;
            next_s.count = s.count - 16'h0001;
            next_s.st = UDC_HOLD;
          end
        end
      end
      UDC_HOLD: begin
        // wait out the write pulse so a stale empty is not reused
        if (holding_empty_flag && !s.thr_wr) begin
          next_s.thr_wr = 1'b1;
          next_s.buf_full = 1'b0; // [RULE5]
          if (s.count == RST_WORD) begin
            next_s.st = UDC_DONE;
          end else if (s.channel_enable) begin
            next_s.st = UDC_FETCH;
            next_s.mem_req = 1'b1;
          end else begin
            next_s.st = UDC_IDLE;
          end
        end
      end
      UDC_DONE: begin
        tx_set[IRQ_DONE_BIT] = 1'b1; // [RULE15]
        next_s.st = UDC_IDLE;
        if (s.circular_buffer_select) begin
          // circular buffer restarts from the saved base
          next_s.addr = s.base_addr; // [RULE17]
          next_s.count = s.base_count;
        end else begin
          // chain on; descriptor consumed until software re-arms
          next_s.cur_desc = s.next_desc; // [RULE2] [RULE4] [RULE11]
          next_s.desc_rdy = 1'b1; // [RULE12]
        end
      end
      default: next_s.st = UDC_IDLE;
    endcase

    // irq is computed from the next flags so that it rises in
    // the same cycle as the flag that causes it
    // losing a set to a clear would hide an event for good
    // sticky flags, a set in the clear cycle wins
    next_s.tx_flags = ((s.tx_flags & ~tx_clr) | tx_set) & TX_IRQ_MASK_BITS; // [RULE14] [RULE19]
    next_s.rx_flags = ((s.rx_flags & ~rx_clr) | rx_set) & RX_IRQ_MASK_BITS; // [RULE1] [RULE19]
    next_s.irq = |(next_s.tx_flags & next_s.tx_mask) || |(next_s.rx_flags & next_s.rx_mask);
  end

  // reset only loads constants; everything else goes through
  // next_s so that ce gates every flop alike
  // a frozen ce also stalls the bus answer; the master waits
  // single state register, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s.st <= UDC_IDLE;
      s.apb_done <= 1'b0;
      s.rdata <= 32'h0000_0000;
      s.slverr <= 1'b0;
      s.cur_desc <= RST_WORD; // [RULE2]
      s.channel_enable <= 1'b0; // [RULE3]
      s.circular_buffer_select <= 1'b0;
      s.err_status <= 1'b0;
      s.buf_full <= 1'b0;
      s.page <= RST_PAGE; // [RULE7]
      s.addr <= RST_WORD; // [RULE9]
      s.count <= RST_WORD; // [RULE10]
      s.base_addr <= RST_WORD;
      s.base_count <= RST_WORD;
      s.next_desc <= RST_WORD;
      s.desc_rdy <= RST_DESC_RDY; // [RULE12]
      s.tx_flags <= RST_WORD; // [RULE14]
      s.tx_mask <= RST_WORD;
      s.rx_flags <= RST_WORD;
      s.rx_mask <= RST_WORD;
      s.empty_d <= 1'b1; // pin idles empty; a zero here fakes an edge
      s.mem_req <= 1'b0;
      s.thr_wr <= 1'b0;
      s.thr_data <= RST_WORD;
      s.irq <= 1'b0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // plain wires from flops keep every output free of
  // combinational paths back to the inputs
  // outputs straight from the state flops
  assign prdata = s.rdata;
  assign pready = s.apb_done;
  assign pslverr = s.slverr;
  assign mem_req = s.mem_req;
  assign mem_addr = s.addr;
  assign mem_page = s.page[7:0];
  assign mem_space = s.page[PAGE_SPACE_BIT];
  assign tx_holding_wr = s.thr_wr;
  assign tx_holding_reg = s.thr_data;
  assign irq = s.irq;
endmodule : udc_top

// ---- test/udc_mem_model.sv ----
`timescale 1ns/1ps
// memory read port and transmitter holding register
module udc_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  output logic mem_ack,
  output logic mem_err,
  output logic [15:0] mem_rdata,
  input wire logic tx_holding_wr,
  output logic holding_empty_flag,
  input wire logic slow,
  input wire logic err_now,
  input wire logic kick
);
  logic [1:0] wait_cnt; // read latency
  // one read answered at a time; kick marks the holding register full for one cycle by hand
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {mem_ack, mem_err, wait_cnt, mem_rdata} <= '0;
      holding_empty_flag <= 1'b1;
    end else begin
      holding_empty_flag <= !(tx_holding_wr || kick);
      mem_ack <= 1'b0;
      mem_err <= 1'b0;
      mem_rdata <= ~mem_rdata; // no valid data between answers
      if (mem_req && !mem_ack) begin
        wait_cnt <= wait_cnt + 2'h1;
        if (wait_cnt >= {slow, 1'b0}) begin
          {mem_ack, mem_err, wait_cnt} <= {1'b1, err_now, 2'h0};
          mem_rdata <= mem_addr ^ 16'ha5a5;
        end
      end
    end
  end
endmodule : udc_mem_model

// ---- test/udc_properties.sv ----
`timescale 1ns/1ps
// watches bus answers, memory handshake and holding writes
module udc_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_page,
  input wire logic mem_space,
  input wire logic mem_ack,
  input wire logic mem_err,
  input wire logic holding_empty_flag,
  input wire logic tx_holding_wr
);
  // a frozen clock enable holds answers back, so checking pauses
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);
  a_ready_next: assert property (psel && penable && !pready |=> pready) else $error("no answer");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_err_ready: assert property (pslverr |-> pready) else $error("lone error");
  a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0) else $error("upper bits");
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable({mem_space, mem_page, mem_addr}))
    else $error("request moved");
  a_req_drop: assert property (mem_req && mem_ack |=> !mem_req) else $error("request kept");
  a_err_stop: assert property (mem_req && mem_ack && mem_err |=> !mem_req [*4]) else $error("fetch on");
  a_wr_pulse: assert property (tx_holding_wr |=> !tx_holding_wr) else $error("long write");
  a_wr_empty: assert property (tx_holding_wr |-> $past(holding_empty_flag)) else $error("holding full");
  a_reset_quiet: assert property ($rose(presetn) |-> !pready && !mem_req) else $error("busy");
  c_refused: cover property (pslverr);
  c_fetch_err: cover property (mem_ack && mem_err);
  c_two_words: cover property (tx_holding_wr ##[1:30] tx_holding_wr);
endmodule : udc_properties
bind udc_top udc_properties chk_i (.pclk, .presetn, .ce, .psel, .penable, .prdata, .pready, .pslverr, .mem_req,
  .mem_addr, .mem_page, .mem_space, .mem_ack, .mem_err, .holding_empty_flag, .tx_holding_wr);

// ---- test/udc_top_bench.sv ----
`timescale 1ns/1ps
module udc_top_bench;
  import udc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, err_now = 0, kick = 0, rx_ev = 0;
  logic pready, pslverr, mem_req, mem_space, mem_ack, mem_err, hef, txw, irq, e, ia;
  logic ce = 1; // clock enable, dropped once to check the freeze
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [15:0] mem_addr, mem_rdata, txd, base, d;
  logic [7:0] mem_page;
  logic [9:0] ix [9] = '{IDX_RX_IRQ, IDX_CUR_DESC, IDX_CFG, IDX_PAGE, IDX_ADDR, IDX_COUNT, IDX_NEXT_DESC,
    IDX_DESC_RDY, IDX_TX_IRQ};
  int n_errors = 0, n_tests = 0, seed = 32'he68ada3c, widx = 0;
  udc_top dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .mem_req, .mem_addr, .mem_page, .mem_space, .mem_ack, .mem_err, .mem_rdata, .holding_empty_flag(hef),
    .tx_holding_wr(txw), .tx_holding_reg(txd), .rx_irq_event(rx_ev), .irq);
  udc_mem_model mem (.pclk, .presetn, .mem_req, .mem_addr, .mem_ack, .mem_err, .mem_rdata, .tx_holding_wr(txw),
    .holding_empty_flag(hef), .slow, .err_now, .kick);
  initial forever #12.5 pclk = ~pclk;
  function automatic logic [31:0] word_at(input int k);
    return {16'h0, 16'(base + 16'(k % 3)) ^ 16'ha5a5};
  endfunction : word_at
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // one bus transfer; holds the request until ready is seen
  task automatic apb(input logic w, input logic [9:0] i, input logic [15:0] wd);
    int t;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, i, 2'b00, 16'h0, wd};
    @(posedge pclk);
    penable <= 1;
    t = 0;
    do begin @(posedge pclk); t++; end while (pready !== 1'b1 && t < 50);
    if (t >= 50) begin n_errors++; close_out; end
    {r, e} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic rd(input string nm, input logic [9:0] i, input logic [31:0] m, input logic [31:0] x);
    apb(0, i, 0);
    chk(nm, r & m, x);
  endtask : rd
  task automatic poll(input logic [9:0] i, input logic [15:0] m);
    int t;
    t = 0;
    do begin apb(0, i, 0); t++; end while ((r[15:0] & m) === 16'h0 && t < 100);
    if (t >= 100) begin n_errors++; close_out; end
  endtask : poll
  // every holding write carries the next word of the circular buffer
  always @(posedge pclk) if (txw === 1'b1) begin
    chk("word", {16'h0, txd}, word_at(widx));
    widx++;
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    foreach (ix[j]) rd("reset", ix[j], '1, 0);
    apb(1, 10'h1ff, 16'hffff);
    chk("unmapped", e, 1);
    for (int j = 1; j < 6; j++) begin
      d = $random(seed);
      apb(1, ix[j], d & 16'hefff);
      rd("locked", ix[j], '1, 0);
    end
    d = $random(seed);
    apb(1, IDX_NEXT_DESC, d);
    rd("next", IDX_NEXT_DESC, '1, d);
    apb(1, IDX_DESC_RDY, 16'hffff);
    rd("ready", IDX_DESC_RDY, '1, 1);
    apb(1, IDX_CFG, 16'h1000);
    rd("mode", IDX_CFG, '1, 32'h1000);
    apb(1, IDX_PAGE, d);
    rd("page", IDX_PAGE, '1, d[8:0]);
    base = $random(seed);
    apb(1, IDX_ADDR, base);
    rd("addr", IDX_ADDR, '1, base);
    apb(1, IDX_COUNT, 3);
    rd("count", IDX_COUNT, '1, 3);
    $display("register test done");
    slow <= 1;
    apb(1, IDX_CFG, 16'h9000);
    rd("live", IDX_CFG, 32'h9010, 32'h9010);
    poll(IDX_TX_IRQ, 16'h8000);
    apb(1, IDX_CFG, 16'h1000);
    chk("words", widx > 2, 1);
    repeat (10) @(posedge pclk);
    apb(1, IDX_TX_IRQ, 16'hc001);
    rd("w1c", IDX_TX_IRQ, '1, 0);
    $display("transfer test done");
    err_now <= 1;
    apb(1, IDX_COUNT, 3);
    apb(1, IDX_CFG, 16'h9000);
    poll(IDX_TX_IRQ, 16'h4000);
    chk("reserved", r & 32'hffff3ffe, 0);
    rd("off", IDX_CFG, 32'h8000, 0);
    apb(1, IDX_TX_IRQ, 0);
    rd("kept", IDX_TX_IRQ, 32'h4000, 32'h4000);
    apb(1, IDX_TX_IRQ, 16'h4000);
    rd("clear", IDX_TX_IRQ, 32'h4000, 0);
    $display("error test done");
    kick <= 1;
    @(posedge pclk);
    kick <= 0;
    rd("empty", IDX_TX_IRQ, 1, 1);
    apb(1, IDX_TX_MASK, 16'hffff);
    repeat (2) @(posedge pclk);
    ia = irq;
    apb(1, IDX_TX_MASK, 0);
    repeat (2) @(posedge pclk);
    chk("mask on", ia, 1);
    chk("mask off", irq, 0);
    apb(1, IDX_TX_IRQ, 1);
    rd("pend", IDX_TX_IRQ, 1, 0);
    rx_ev <= 1;
    @(posedge pclk);
    rx_ev <= 0;
    rd("rx", IDX_RX_IRQ, '1, 1);
    apb(1, IDX_RX_IRQ, 16'hfffe);
    rd("rx kept", IDX_RX_IRQ, '1, 1);
    apb(1, IDX_RX_MASK, 16'hffff);
    repeat (2) @(posedge pclk);
    chk("rx irq", irq, 1);
    apb(1, IDX_RX_IRQ, 1);
    rd("rx w1c", IDX_RX_IRQ, '1, 0);
    chk("rx quiet", irq, 0);
    // a frozen clock enable must swallow an event
    ce <= 0;
    rx_ev <= 1;
    @(posedge pclk);
    {ce, rx_ev} <= 2'b10;
    rd("frozen", IDX_RX_IRQ, '1, 0);
    $display("interrupt test done");
    // descriptor mode: one word, then chain to the next descriptor
    err_now <= 0;
    apb(1, IDX_ADDR, base + 16'(widx % 3));
    apb(1, IDX_COUNT, 1);
    apb(1, IDX_NEXT_DESC, d);
    apb(1, IDX_DESC_RDY, 0);
    apb(1, IDX_CFG, 16'h8000);
    poll(IDX_TX_IRQ, 16'h8000);
    rd("drained", IDX_COUNT, '1, 0);
    rd("chain", IDX_CUR_DESC, '1, d);
    rd("consumed", IDX_DESC_RDY, '1, 1);
    rd("link mode", IDX_CFG, 32'h9000, 32'h8000);
    $display("descriptor test done");
    // a second reset after the descriptor run, with the channel still enabled, must bring back the reset values
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    rd("rearm", IDX_CUR_DESC, '1, 0);
    rd("rearm irq", IDX_TX_IRQ, '1, 0);
    $display("reset test done");
    close_out;
  end
endmodule : udc_top_bench
